// >>> shared/dspmac_pkg.sv
// constants, field layout and types shared by the multiply-accumulate slice
// assumes a single 100 MHz clock and a 32-bit AXI4-Lite register port
package dspmac_pkg;

  // datapath widths at the widest native mode
  localparam int OPND_W  = 36;
  localparam int EXT_W   = OPND_W + 1;
  localparam int PROD_W  = 2 * OPND_W;
  localparam int ACC_W   = PROD_W;
  localparam int SER_W   = 9;
  localparam int NAT9    = 9;
  localparam int NAT18   = 18;
  localparam int NSRC    = 4;
  localparam int SEL_W   = 2;
  localparam int IN_W    = 2 * OPND_W + 2;
  localparam int PIPE_W  = PROD_W + 2;

  // native operand widths; the fourth code is illegal and falls back to x36
  typedef enum logic [1:0] {
    DSPMAC_X9,
    DSPMAC_X18,
    DSPMAC_X36
  } dspmac_width_e;

  // register map, byte addresses
  localparam int           AXI_AW     = 8;
  localparam logic [7:0]   REG_CTRL   = 8'h00;
  localparam logic [7:0]   REG_STATUS = 8'h04;
  localparam logic [7:0]   REG_MASK   = 8'h08;
  localparam logic [7:0]   REG_ACC0   = 8'h0C;
  localparam logic [7:0]   REG_ACC1   = 8'h10;
  localparam logic [7:0]   REG_ACC2   = 8'h14;

  // control register fields
  localparam int F_IN_EN    = 0;
  localparam int F_PIPE_EN  = 1;
  localparam int F_OUT_EN   = 2;
  localparam int F_ACC_EN   = 3;
  localparam int F_WIDTH    = 4;
  localparam int F_IN_CE    = 8;
  localparam int F_PIPE_CE  = 10;
  localparam int F_OUT_CE   = 12;
  localparam int F_IN_RST   = 16;
  localparam int F_PIPE_RST = 18;
  localparam int F_OUT_RST  = 20;
  localparam int F_STAT_OVF = 0;

  localparam logic [31:0] CTRL_RESET = 32'h0000_002F;
  localparam logic [31:0] CTRL_WMASK = 32'h0033_3F3F;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// >>> logic/dspmac_stage.sv
// one optional register stage with selectable clock-enable and reset sources
// assumes the select sources come from fabric logic on the same clock
`timescale 1ns/1ps
module dspmac_stage
  import dspmac_pkg::*;
#(
  parameter int W = IN_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             stage_en,
  input  wire logic [SEL_W-1:0] ce_sel,
  input  wire logic [SEL_W-1:0] rst_sel,
  input  wire logic [NSRC-1:0]  ce_src,
  input  wire logic [NSRC-1:0]  rst_src,
  input  wire logic [W-1:0]     d,
  output logic      [W-1:0]     q
);

  typedef struct packed {
    logic [W-1:0] data;
  } dspmac_stage_s;

  dspmac_stage_s st;
  dspmac_stage_s next_st;

  // source selection
  // selected reset beats selected enable so a stalled stage can still be cleared
  always_comb begin
    next_st = st;
    if (ce && rst_src[rst_sel]) begin
      next_st.data = '0;
    end else if (ce && ce_src[ce_sel]) begin
      next_st.data = d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = stage_en ? st.data : d;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_stage_hold;
    ce && !ce_src[ce_sel] && !rst_src[rst_sel] && stage_en ##1 stage_en |-> q == $past(q);
  endproperty
  a_stage_hold: assert property (p_stage_hold) else $error("stage moved while its enable was low");

  property p_stage_clear;
    ce && rst_src[rst_sel] ##1 stage_en |-> q == '0;
  endproperty
  a_stage_clear: assert property (p_stage_clear) else $error("stage not cleared by its reset source");

endmodule

// >>> logic/dspmac_accum.sv
// accumulator adder with wrap-around overflow detection
// assumes the caller registers sum and overflow on its own enable
`timescale 1ns/1ps
module dspmac_accum
  import dspmac_pkg::*;
(
  input  wire logic [ACC_W-1:0] acc,
  input  wire logic [ACC_W-1:0] addend,
  input  wire logic             is_signed,
  input  wire logic             subtract,
  output logic      [ACC_W-1:0] sum,
  output logic                  overflow
);

  logic [ACC_W:0] raw;
  logic           same_sign;
  logic           flip;

  // one extra bit holds the carry on add and the borrow on subtract
  always_comb begin
    raw       = subtract ? ({1'b0, acc} - {1'b0, addend}) : ({1'b0, acc} + {1'b0, addend});
    sum       = raw[ACC_W-1:0];
    same_sign = acc[ACC_W-1] == addend[ACC_W-1];
    flip      = raw[ACC_W-1] != acc[ACC_W-1];
    // signed wrap
    // subtracting flips the effective sign of the addend
    if (is_signed) begin
      overflow = (subtract ? !same_sign : same_sign) && flip;
    end else begin
      overflow = raw[ACC_W];
    end
  end

endmodule

// >>> logic/dspmac_top.sv
// multiply and multiply-accumulate slice with an AXI4-Lite configuration port
// assumes fabric drives operands, controls and the four enable and reset sources on clk
// Behaviour
// - The multiply output is the plain product, with no adder in its path.
// - Input, pipeline and output stages are each enabled or bypassed by configuration.
// - Each stage picks one of four enable sources; input and output stages pick one of four resets, the pipeline stage always reset source 0.
// - Unsigned accumulation wraps and flags overflow when an add makes the result smaller or a subtract makes it larger.
// - Signed accumulation flags overflow when like-signed values sum to the other sign.
// - Overflow is a one-cycle pulse per event, never a held flag.
// - Signed or unsigned operand treatment may change on any cycle.
// - Add or subtract in the accumulator may change on any cycle.
// - Operand loading may alternate between parallel and serial shifting.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module dspmac_top
  import dspmac_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic              clk_enable_src0,
  input  wire logic              clk_enable_src1,
  input  wire logic              clk_enable_src2,
  input  wire logic              clk_enable_src3,
  input  wire logic              reset_src0,
  input  wire logic              reset_src1,
  input  wire logic              reset_src2,
  input  wire logic              reset_src3,
  input  wire logic [OPND_W-1:0] operand_a,
  input  wire logic [OPND_W-1:0] operand_b,
  input  wire logic [SER_W-1:0]  serial_in,
  input  wire logic              load_serial,
  input  wire logic              operands_signed,
  input  wire logic              acc_subtract,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [PROD_W-1:0]      product_out,
  output logic [ACC_W-1:0]       acc_out,
  output logic                   overflow,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [OPND_W-1:0] ser_shift;
    logic [ACC_W-1:0]  acc;
    logic              ovf;
    logic              irq;
    logic [31:0]       ctrl;
    logic              stat;
    logic              mask;
    logic              awready;
    logic              wready;
    logic              aw_got;
    logic              w_got;
    logic [AXI_AW-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } dspmac_top_s;

  dspmac_top_s s;
  dspmac_top_s next_s;

  logic [NSRC-1:0]       ce_src;
  logic [NSRC-1:0]       rst_src;
  logic [OPND_W-1:0]     load_a;
  logic [IN_W-1:0]       in_q;
  logic [OPND_W-1:0]     in_a;
  logic [OPND_W-1:0]     in_b;
  logic                  in_sgn;
  logic                  in_sub;
  logic [OPND_W-1:0]     fit_a;
  logic [OPND_W-1:0]     fit_b;
  logic signed [EXT_W-1:0]   mul_a;
  logic signed [EXT_W-1:0]   mul_b;
  logic signed [2*EXT_W-1:0] mul_full;
  logic [PROD_W-1:0]     product;
  logic [PIPE_W-1:0]     pipe_q;
  logic [PROD_W-1:0]     pipe_prod;
  logic                  pipe_sgn;
  logic                  pipe_sub;
  logic [ACC_W-1:0]      acc_sum;
  logic                  acc_ovf;
  logic                  out_ce;
  logic                  out_rst;
  logic                  acc_upd;

  assign ce_src  = {clk_enable_src3, clk_enable_src2, clk_enable_src1, clk_enable_src0};
  assign rst_src = {reset_src3, reset_src2, reset_src1, reset_src0};

  ////////////////////////////////////////////////////////////////////////////
  // operand loading

  // parallel or serial load
  // serial mode shifts a 9-bit lane per cycle into a staging word
  assign load_a = load_serial ? {s.ser_shift[OPND_W-SER_W-1:0], serial_in} : operand_a;

  dspmac_stage #(
    .W(IN_W)
  ) u_in_stage (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .stage_en (s.ctrl[F_IN_EN]),
    .ce_sel   (s.ctrl[F_IN_CE +: SEL_W]),
    .rst_sel  (s.ctrl[F_IN_RST +: SEL_W]),
    .ce_src   (ce_src),
    .rst_src  (rst_src),
    .d        ({load_a, operand_b, operands_signed, acc_subtract}),
    .q        (in_q)
  );

  assign in_a   = in_q[IN_W-1 -: OPND_W];
  assign in_b   = in_q[2 +: OPND_W];
  assign in_sgn = in_q[1];
  assign in_sub = in_q[0];

  ////////////////////////////////////////////////////////////////////////////
  // multiply-only element

  // operands are read at the configured native width; bits above it are replaced by zero or sign fill
  function automatic logic [OPND_W-1:0] fit_operand(input logic [OPND_W-1:0] v,
                                                    input logic [1:0]        wm,
                                                    input logic              sg);
    logic [OPND_W-1:0] r;
    r = v;
    unique case (dspmac_width_e'(wm))
      DSPMAC_X9: begin
        r = {{(OPND_W-NAT9){sg & v[NAT9-1]}}, v[NAT9-1:0]};
      end
      DSPMAC_X18: begin
        r = {{(OPND_W-NAT18){sg & v[NAT18-1]}}, v[NAT18-1:0]};
      end
      DSPMAC_X36: begin
        r = v;
      end
      default: begin
        r = v;
      end
    endcase
    return r;
  endfunction

  assign fit_a = fit_operand(in_a, s.ctrl[F_WIDTH +: 2], in_sgn);
  assign fit_b = fit_operand(in_b, s.ctrl[F_WIDTH +: 2], in_sgn);
  assign mul_a = {in_sgn & fit_a[OPND_W-1], fit_a};
  assign mul_b = {in_sgn & fit_b[OPND_W-1], fit_b};

  assign mul_full = mul_a * mul_b;
  assign product  = mul_full[PROD_W-1:0];

  dspmac_stage #(
    .W(PIPE_W)
  ) u_pipe_stage (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .stage_en (s.ctrl[F_PIPE_EN]),
    .ce_sel   (s.ctrl[F_PIPE_CE +: SEL_W]),
    .rst_sel  (s.ctrl[F_PIPE_RST +: SEL_W]),
    .ce_src   (ce_src),
    .rst_src  (rst_src),
    .d        ({product, in_sgn, in_sub}),
    .q        (pipe_q)
  );

  assign pipe_prod = pipe_q[PIPE_W-1 -: PROD_W];
  assign pipe_sgn  = pipe_q[1];
  assign pipe_sub  = pipe_q[0];

  // output stage
  // a bypassed output stage leaves the product combinational from the pipeline
  dspmac_stage #(
    .W(PROD_W)
  ) u_out_stage (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .stage_en (s.ctrl[F_OUT_EN]),
    .ce_sel   (s.ctrl[F_OUT_CE +: SEL_W]),
    .rst_sel  (s.ctrl[F_OUT_RST +: SEL_W]),
    .ce_src   (ce_src),
    .rst_src  (rst_src),
    .d        (pipe_prod),
    .q        (product_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // accumulator

  dspmac_accum u_accum (
    .acc       (s.acc),
    .addend    (pipe_prod),
    .is_signed (pipe_sgn),
    .subtract  (pipe_sub),
    .sum       (acc_sum),
    .overflow  (acc_ovf)
  );

  // the accumulator register shares the output stage's enable and reset choice
  assign out_ce  = ce_src[s.ctrl[F_OUT_CE +: SEL_W]];
  assign out_rst = rst_src[s.ctrl[F_OUT_RST +: SEL_W]];
  assign acc_upd = ce && s.ctrl[F_ACC_EN] && out_ce && !out_rst;

  ////////////////////////////////////////////////////////////////////////////
  // next state: datapath, registers, bus

  always_comb begin
    next_s = s;
    // serial staging word advances only on serial cycles
    if (load_serial) begin
      next_s.ser_shift = load_a;
    end
    next_s.ovf = 1'b0;
    if (out_rst) begin
      next_s.acc = '0;
    end else if (acc_upd) begin
      next_s.acc = acc_sum;
      next_s.ovf = acc_ovf;
    end
    // write channel: address and data are taken in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_got  = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = RESP_OKAY;
      unique case (s.aw_addr)
        REG_CTRL: begin
          for (int i = 0; i < 4; i++) begin
            if (s.w_strb[i]) begin
              next_s.ctrl[8*i +: 8] = s.w_data[8*i +: 8] & CTRL_WMASK[8*i +: 8];
            end
          end
        end
        REG_MASK: begin
          if (s.w_strb[0]) begin
            next_s.mask = s.w_data[F_STAT_OVF];
          end
        end
        REG_STATUS, REG_ACC0, REG_ACC1, REG_ACC2: begin
          next_s.bresp = RESP_OKAY;
        end
        default: begin
          next_s.bresp = RESP_SLVERR;
        end
      endcase
    end
    // read channel: one read at a time, status clears when read
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      next_s.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        REG_CTRL: begin
          next_s.rdata = s.ctrl;
        end
        REG_STATUS: begin
          next_s.rdata[F_STAT_OVF] = s.stat;
          next_s.stat              = 1'b0;
        end
        REG_MASK: begin
          next_s.rdata[F_STAT_OVF] = s.mask;
        end
        REG_ACC0: begin
          next_s.rdata = s.acc[31:0];
        end
        REG_ACC1: begin
          next_s.rdata = s.acc[63:32];
        end
        REG_ACC2: begin
          next_s.rdata[ACC_W-65:0] = s.acc[ACC_W-1:64];
        end
        default: begin
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end
    // an overflow in the clearing cycle still lands in status
    if (next_s.ovf) begin
      next_s.stat = 1'b1;
    end
    next_s.irq     = next_s.stat & next_s.mask;
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready  = !next_s.w_got && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
  end

  // global enable low freezes everything, the bus included
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s         <= '0;
      s.ctrl    <= CTRL_RESET;
      s.awready <= 1'b1;
      s.wready  <= 1'b1;
      s.arready <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign acc_out       = s.acc;
  assign overflow      = s.ovf;
  assign irq           = s.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [PROD_W-1:0] ref36u;
  logic [PROD_W-1:0] ref9u;
  logic [PROD_W-1:0] ref9s;
  logic              all_bypass;
  logic              clean;

  assign ref36u     = {36'h0, operand_a} * {36'h0, operand_b};
  assign ref9u      = {63'h0, operand_a[8:0]} * {63'h0, operand_b[8:0]};
  assign ref9s      = {{63{operand_a[8]}}, operand_a[8:0]} * {{63{operand_b[8]}}, operand_b[8:0]};
  assign all_bypass = !s.ctrl[F_IN_EN] && !s.ctrl[F_PIPE_EN] && !s.ctrl[F_OUT_EN] && !load_serial;
  assign clean      = ce && (&ce_src) && !(|rst_src) && !load_serial && !operands_signed &&
                      (s.ctrl[F_OUT_EN:F_IN_EN] == 3'h7) && (s.ctrl[F_WIDTH +: 2] == 2'h2);

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_plain_product;
    all_bypass && s.ctrl[F_WIDTH +: 2] == 2'h2 && !operands_signed |-> product_out == ref36u;
  endproperty
  a_plain_product: assert property (p_plain_product) else $error("bypassed product wrong");

  sequence s_clean3;
    clean [*3];
  endsequence
  property p_stage_latency;
    s_clean3 |=> product_out == $past(ref36u, 3);
  endproperty
  a_stage_latency: assert property (p_stage_latency) else $error("three-stage latency wrong");

  property p_unsigned_ovf;
    acc_upd && !pipe_sgn && !pipe_sub |=> overflow == (acc_out < $past(acc_out));
  endproperty
  a_unsigned_ovf: assert property (p_unsigned_ovf) else $error("unsigned overflow wrong");

  property p_signed_ovf;
    acc_upd && pipe_sgn && !pipe_sub && (s.acc[ACC_W-1] == pipe_prod[ACC_W-1])
      |=> overflow == (acc_out[ACC_W-1] != $past(acc_out[ACC_W-1]));
  endproperty
  a_signed_ovf: assert property (p_signed_ovf) else $error("signed overflow wrong");

  property p_ovf_pulse;
    ce && !acc_upd |=> !overflow;
  endproperty
  a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow held past its cycle");

  property p_sign_switch;
    all_bypass && s.ctrl[F_WIDTH +: 2] == 2'h0 |-> product_out == (operands_signed ? ref9s : ref9u);
  endproperty
  a_sign_switch: assert property (p_sign_switch) else $error("signedness not applied");

  property p_addsub;
    acc_upd |=> acc_out == ($past(pipe_sub) ? $past(acc_out) - $past(pipe_prod)
                                            : $past(acc_out) + $past(pipe_prod));
  endproperty
  a_addsub: assert property (p_addsub) else $error("add or subtract wrong");

  sequence s_serial4;
    (ce && load_serial) [*4];
  endsequence
  property p_serial;
    s_serial4 |=> s.ser_shift == {$past(serial_in, 4), $past(serial_in, 3),
                                  $past(serial_in, 2), $past(serial_in, 1)};
  endproperty
  a_serial: assert property (p_serial) else $error("serial load wrong");

endmodule

// >>> test/dspmac_fabric.sv
// fabric-side model: widens and drives operands and controls, counts overflow pulses
// assumes the bench calls put() right after a rising edge of clk
`timescale 1ns/1ps
module dspmac_fabric
  import dspmac_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              overflow,
  output logic      [OPND_W-1:0] operand_a,
  output logic      [OPND_W-1:0] operand_b,
  output logic                   operands_signed,
  output logic                   acc_subtract,
  output logic      [31:0]       ovf_count
);
  initial begin
    operand_a = '0;
    operand_b = '0;
    operands_signed = 1'b0;
    acc_subtract = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // zero fill or sign fill
  function automatic logic [OPND_W-1:0] widen(input logic [OPND_W-1:0] v, input logic [5:0] n, input logic sg);
    logic [OPND_W-1:0] r;
    r = v;
    for (int i = 0; i < OPND_W; i++)
      if (i >= n) r[i] = sg & v[n-1];
    return r;
  endfunction
  // new operands drive out in the same time step as the call, held until the next call
  task automatic put(input logic [OPND_W-1:0] a, b, input logic [5:0] n, input logic sg, sb);
    operand_a <= widen(a, n, sg);
    operand_b <= widen(b, n, sg);
    operands_signed <= sg;
    acc_subtract <= sb;
  endtask
  ////////////////////////////////////////////////////////////////
  // wider accumulator by pulse count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) ovf_count <= '0;
    else if (overflow === 1'b1) ovf_count <= ovf_count + 32'h1;
  end
endmodule

// >>> test/tb_top.sv
// self-checking bench for the multiply-accumulate slice
// assumes dspmac_fabric as operand source and the package register map
`timescale 1ns/1ps
module tb_top;
  import dspmac_pkg::*;
  typedef struct packed {
    logic [35:0] a, b;
    logic [5:0]  n;
    logic        sg;
    logic [71:0] p;
  } dspmac_row_s;
  logic clk, rst, ce, load_serial, operands_signed, acc_subtract, overflow, irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0]        ce_src, rst_src, s_axi_wstrb;
  logic [SER_W-1:0]  serial_in;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, ovf_count, rd;
  logic [1:0]        s_axi_bresp, s_axi_rresp, resp;
  logic [OPND_W-1:0] operand_a, operand_b;
  logic [PROD_W-1:0] product_out;
  logic [ACC_W-1:0]  acc_out;
  int n_fail = 0;
  int check_count = 0;
  dspmac_row_s rows [5] = '{
    '{36'hF_FFFF_FFFF, 36'hF_FFFF_FFFF, 6'h24, 1'b0, 72'hFF_FFFF_FFE0_0000_0001},
    '{36'hF_FFFF_FFFF, 36'hF_FFFF_FFFF, 6'h24, 1'b1, 72'h1},
    '{36'hA, 36'h5, 6'h04, 1'b1, 72'hFF_FFFF_FFFF_FFFF_FFE2},
    '{36'hA, 36'h5, 6'h04, 1'b0, 72'h32},
    '{36'h8_0000_0000, 36'h8_0000_0000, 6'h24, 1'b1, 72'h40_0000_0000_0000_0000}};
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  dspmac_fabric fab (.clk, .rst, .overflow, .operand_a, .operand_b, .operands_signed, .acc_subtract, .ovf_count);
  dspmac_top dut (.clk, .rst, .ce, .clk_enable_src0(ce_src[0]), .clk_enable_src1(ce_src[1]),
    .clk_enable_src2(ce_src[2]), .clk_enable_src3(ce_src[3]), .reset_src0(rst_src[0]),
    .reset_src1(rst_src[1]), .reset_src2(rst_src[2]), .reset_src3(rst_src[3]), .operand_a, .operand_b,
    .serial_in, .load_serial, .operands_signed, .acc_subtract, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .product_out, .acc_out, .overflow, .irq);
  ////////////////////////////////////////////////////////////////
  // verdict and the single exit point
  task automatic test_done;
    if (n_fail == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [71:0] g, e);
    check_count++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
      n_fail++;
    end
  endtask
  task automatic hang(input int n);
    if (n > 50) begin
      n_fail++;
      test_done();
    end
  endtask
  // write: both channels offered together, each dropped once taken
  task automatic axw(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      hang(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      hang(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // clears the accumulator through reset source 0, runs k products, watches pulses
  task automatic acc_run(input logic [35:0] a, input logic s, d, input int k, input logic [71:0] ea, input int ep);
    int c0;
    int hi;
    hi = 0;
    @(posedge clk);
    rst_src <= 4'h1;
    fab.put(36'h0, 36'h0, 6'h24, s, d);
    @(posedge clk);
    rst_src <= 4'h0;
    c0 = ovf_count;
    for (int i = 0; i < k; i++) begin
      fab.put(a, a, 6'h24, s, d);
      @(posedge clk);
    end
    fab.put(36'h0, 36'h0, 6'h24, s, d);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #1 hi += overflow;
    end
    chk(acc_out, ea);
    chk(ovf_count - c0, ep);
    chk(hi, ep);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {ce, ce_src, rst_src, s_axi_wstrb} = 13'h1_F0F;
    {load_serial, serial_in, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    axr(REG_CTRL, rd, resp);
    chk(rd, CTRL_RESET);
    axr(8'h40, rd, resp);
    chk(resp, RESP_SLVERR);
    axw(REG_MASK, 32'h0, resp);
    axw(REG_CTRL, 32'h0000_0020, resp);
    chk(resp, RESP_OKAY);
    // stages bypassed: product follows the operands in the same cycle
    foreach (rows[i]) begin
      @(posedge clk);
      fab.put(rows[i].a, rows[i].b, rows[i].n, rows[i].sg, 1'b0);
      #1 chk(product_out, rows[i].p);
    end
    // four serial lanes then a parallel load
    @(posedge clk);
    fab.put(36'h0, 36'h1, 6'h24, 1'b0, 1'b0);
    load_serial <= 1'b1;
    serial_in <= 9'h1AB;
    @(posedge clk);
    serial_in <= 9'h0CD;
    @(posedge clk);
    serial_in <= 9'h1EF;
    @(posedge clk);
    serial_in <= 9'h012;
    #1 chk(product_out, 72'hD_5B37_DE12);
    @(posedge clk);
    load_serial <= 1'b0;
    fab.put(36'h3, 36'h7, 6'h24, 1'b0, 1'b0);
    #1 chk(product_out, 72'h15);
    // x9 lane mode: only the low nine bits of each operand count
    axw(REG_CTRL, 32'h0000_0000, resp);
    fab.put(36'h1FA, 36'h5, 6'h09, 1'b1, 1'b0);
    #1 chk(product_out, 72'hFF_FFFF_FFFF_FFFF_FFE2);
    @(posedge clk);
    fab.put(36'hF_FFFF_FE03, 36'h7, 6'h24, 1'b0, 1'b0);
    #1 chk(product_out, 72'h15);
    @(posedge clk);
    fab.put(36'h3, 36'h7, 6'h24, 1'b0, 1'b0);
    // all three stages on: one word, three edges of latency
    axw(REG_CTRL, CTRL_RESET, resp);
    fab.put(36'h3, 36'h5, 6'h24, 1'b0, 1'b0);
    @(posedge clk);
    fab.put(36'h0, 36'h0, 6'h24, 1'b0, 1'b0);
    @(posedge clk);
    #1 chk(product_out, 72'h15);
    @(posedge clk);
    #1 chk(product_out, 72'hF);
    @(posedge clk);
    #1 chk(product_out, 72'h0);
    // selected enable source low: every stage holds its word
    @(posedge clk);
    ce_src <= 4'h0;
    fab.put(36'h3, 36'h5, 6'h24, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    #1 chk(product_out, 72'h0);
    @(posedge clk);
    ce_src <= 4'hF;
    acc_run(36'hF_FFFF_FFFF, 1'b0, 1'b0, 2, 72'hFF_FFFF_FFC0_0000_0002, 1);
    acc_run(36'h8_0000_0000, 1'b1, 1'b0, 2, 72'h80_0000_0000_0000_0000, 1);
    acc_run(36'h1, 1'b0, 1'b1, 1, 72'hFF_FFFF_FFFF_FFFF_FFFF, 1);
    acc_run(36'hF_FFFF_FFFF, 1'b1, 1'b1, 1, 72'hFF_FFFF_FFFF_FFFF_FFFF, 0);
    // sticky status held while masked, raised once unmasked, cleared by read
    chk(irq, 1'b0);
    axw(REG_MASK, 32'h1, resp);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b1);
    axr(REG_STATUS, rd, resp);
    chk(rd, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    axr(REG_STATUS, rd, resp);
    chk(rd, 32'h0);
    test_done();
  end
endmodule
